// File: dv/pmg_cpu_model.sv
// Behavioural CPU core, interrupt controller and watchdog facing the controller
`timescale 1ns/1ns
module pmg_cpu_model
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Commands from the bench
   input wire logic i_req_wait,
   input wire logic i_req_wdt,
   input wire logic i_irq_on,
   input wire logic [2:0] i_irq_prio,
   input wire logic i_irq_src,
   // Controller side
   input wire logic i_cpu_clk_en,
   output logic o_wait_exec,
   output logic o_wdt_timeout,
   output logic o_irq_req,
   output logic [2:0] o_irq_prio,
   output logic o_irq_sleep_src
);
   logic taken; // Request already serviced by a running CPU
   // A halted CPU issues no wait; a running CPU services the pending request
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_wait_exec <= 1'b0;
         o_wdt_timeout <= 1'b0;
         o_irq_req <= 1'b0;
         o_irq_prio <= 3'h0;
         o_irq_sleep_src <= 1'b0;
         taken <= 1'b0;
      end
      else
      begin
         o_wait_exec <= i_req_wait & i_cpu_clk_en;
         o_wdt_timeout <= i_req_wdt;
         taken <= i_irq_on & (taken | (o_irq_req & i_cpu_clk_en));
         o_irq_req <= i_irq_on & ~taken & ~(o_irq_req & i_cpu_clk_en);
         // Released priority lines toggle so no stale value is read
         o_irq_prio <= i_irq_on ? i_irq_prio : ~o_irq_prio;
         o_irq_sleep_src <= i_irq_src;
      end
   end
endmodule : pmg_cpu_model

// File: dv/pmg_power_ctrl_props.sv
// Checker of the power-mode controller, watching the top module's ports
`timescale 1ns/1ns
module pmg_power_ctrl_props
#(
   parameter int NUM_GATES = 224, // Gate bits in the bank
   parameter int PRIO_W = 3 // Interrupt priority width
)
(
   // Clock, reset and requests
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wait_exec,
   input wire logic [PRIO_W-1:0] i_cpu_prio,
   input wire logic i_irq_req,
   input wire logic [PRIO_W-1:0] i_irq_prio,
   input wire logic i_irq_sleep_src,
   input wire logic i_wdt_timeout,
   input wire logic [NUM_GATES-1:0] i_periph_stop_idle,
   // Outputs watched
   input wire logic o_hresp,
   input wire logic o_cpu_clk_en,
   input wire logic o_wdt_clear,
   input wire logic o_wdt_wake_irq,
   input wire logic o_pbclk_en,
   input wire logic o_clk_mon_en,
   input wire logic o_brownout_en,
   input wire logic o_io_hold,
   input wire logic o_vreg_standby,
   input wire logic [NUM_GATES-1:0] o_periph_clk_en,
   input wire logic [NUM_GATES-1:0] o_periph_rst,
   input wire logic [NUM_GATES-1:0] o_periph_sfr_ok
);
   // Idle as seen at the ports: CPU stopped, bus clocks running, pins free
   wire idle = !o_cpu_clk_en && o_pbclk_en && !o_io_hold;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   chk_wait_halts: assert property (i_wait_exec && o_cpu_clk_en |=> !o_cpu_clk_en)
      else $error("wait left the CPU clocked");
   chk_sleep_gates: assert property (o_io_hold |-> !o_cpu_clk_en && !o_pbclk_en
      && !o_clk_mon_en) else $error("clocks running in sleep");
   chk_fixed_outs: assert property (o_brownout_en && !o_wdt_clear && !o_hresp)
      else $error("fixed output changed");
   chk_sleep_holds: assert property (o_io_hold && !i_wdt_timeout && !(i_irq_req && i_irq_sleep_src)
      |=> o_io_hold)
      else $error("sleep left without cause");
   chk_sleep_wake: assert property (o_io_hold && i_irq_req && i_irq_sleep_src && i_irq_prio > i_cpu_prio
      |=> !o_io_hold && !o_pbclk_en ##[1:300] o_cpu_clk_en)
      else $error("sleep wake failed");
   chk_sleep_to_idle: assert property (o_io_hold && !i_wdt_timeout && i_irq_req && i_irq_sleep_src
      && i_irq_prio <= i_cpu_prio |=> idle)
      else $error("low wake did not reach idle");
   chk_idle_wake: assert property (idle && i_irq_req && i_irq_prio > i_cpu_prio |=> o_cpu_clk_en)
      else $error("idle did not wake");
   chk_idle_stays: assert property (idle && !i_wdt_timeout && !(i_irq_req && i_irq_prio > i_cpu_prio)
      |=> idle)
      else $error("idle left without cause");
   chk_idle_wdt: assert property (idle && i_wdt_timeout |=> o_cpu_clk_en ##[0:1] o_wdt_wake_irq)
      else $error("watchdog wake from idle failed");
   chk_idle_clocks: assert property (idle && $stable(i_periph_stop_idle)
      |-> o_periph_clk_en == ~(o_periph_rst | i_periph_stop_idle))
      else $error("idle peripheral clocks wrong");
   chk_run_clocks: assert property (o_cpu_clk_en |-> o_pbclk_en && o_clk_mon_en && !o_io_hold
      && o_periph_clk_en == ~o_periph_rst)
      else $error("run clocks wrong");
   chk_gate_pairs: assert property (o_periph_sfr_ok == ~o_periph_rst
      && (o_periph_rst & o_periph_clk_en) == '0)
      else $error("gated peripheral not isolated");
   chk_vreg_sleep: assert property (o_vreg_standby |-> o_io_hold)
      else $error("standby outside sleep");
endmodule : pmg_power_ctrl_props

// File: dv/tb.sv
// Self-checking testbench of the power-mode controller
`timescale 1ns/1ns
module tb;
   import pmg_pkg::*;
   logic clk, rst_n, hsel, hwrite, hrdy, hresp, cpu_en, wait_x, irq, isrc, wdt, wclr, wirq;
   logic pben, fsen, boren, hold, vreg, req_wait, req_wdt, irq_on, irq_s;
   logic [7:0] haddr;
   logic [1:0] htrans, rtc;
   logic [2:0] hsize, cpu_prio, iprio, irq_p;
   logic [31:0] hwdata, hrdata, q;
   logic [223:0] stop, pclk, prst, pok;
   int miscompares, samples_checked;
   logic [7:0] ofs [7] = '{PMG_GATE_ANALOG_OFS, PMG_GATE_CMP_OPAMP_OFS, PMG_GATE_CAPCMP_OFS,
      PMG_GATE_TMR_PWM_OFS, PMG_GATE_SERIAL_OFS, PMG_GATE_REFCLK_ENC_OFS, PMG_GATE_DMA_OFS};
   pmg_power_ctrl #(.SLEEP_CAPABLE(224'h2)) dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_wait_exec(wait_x),
      .i_cpu_prio(cpu_prio), .o_cpu_clk_en(cpu_en), .i_irq_req(irq), .i_irq_prio(iprio),
      .i_irq_sleep_src(isrc), .i_wdt_timeout(wdt), .o_wdt_clear(wclr), .o_wdt_wake_irq(wirq),
      .o_pbclk_en(pben), .o_clk_mon_en(fsen), .o_brownout_en(boren), .o_io_hold(hold),
      .o_rtc_clk_sel(rtc), .o_vreg_standby(vreg), .i_periph_stop_idle(stop), .i_hsel(hsel),
      .o_periph_clk_en(pclk), .o_periph_rst(prst), .o_periph_sfr_ok(pok), .i_haddr(haddr));
   pmg_cpu_model cpu (.i_clk(clk), .i_rst_n(rst_n), .i_req_wait(req_wait), .i_req_wdt(req_wdt),
      .i_irq_on(irq_on), .i_irq_prio(irq_p), .i_irq_src(irq_s), .i_cpu_clk_en(cpu_en),
      .o_wait_exec(wait_x), .o_wdt_timeout(wdt), .o_irq_req(irq), .o_irq_prio(iprio),
      .o_irq_sleep_src(isrc));
   // 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic stop_test;
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   // Compare one value
   task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask : ck
   // Let n edges pass and their updates land
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // One AHB-Lite single word transfer
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      q = hrdata;
   endtask : xfer
   // Read a register and compare it
   task automatic rd_ck(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      ck($sformatf("reg %h", a), e, q);
   endtask : rd_ck
   // CPU executes the wait instruction
   task automatic go_wait;
      @(posedge clk);
      req_wait <= 1'b1;
      @(posedge clk);
      req_wait <= 1'b0;
      step(3);
   endtask : go_wait
   // Interrupt request level, priority and sleep source
   task automatic set_irq(input logic o, input logic [2:0] p, input logic s);
      @(posedge clk);
      irq_on <= o;
      irq_p <= p;
      irq_s <= s;
      step(4);
   endtask : set_irq
   // Watchdog timeout pulse; reports whether a wake interrupt pulsed
   task automatic pulse_wdt(output logic seen);
      @(posedge clk);
      req_wdt <= 1'b1;
      @(posedge clk);
      req_wdt <= 1'b0;
      seen = 1'b0;
      repeat (4)
      begin
         step(1);
         seen = seen | wirq;
      end
   endtask : pulse_wdt
   ////////////////////////////////////////////////////////////////////////////
   // Reset values, unmapped place and read-only status
   task automatic t_regs;
      foreach (ofs[i]) rd_ck(ofs[i], PMG_GATE_RST);
      rd_ck(PMG_RTC_CTRL_OFS, 32'h0);
      rd_ck(8'hfc, 32'h0);
      xfer(PMG_STATUS_OFS, 1'b1, 32'hffff_ffff);
      rd_ck(PMG_STATUS_OFS, 32'h0);
   endtask : t_regs
   // Each gate word disables, resets and isolates its peripherals
   task automatic t_gates;
      logic [31:0] p;
      foreach (ofs[i])
      begin
         p = (32'h1 << i) | 32'h8000_0010;
         xfer(ofs[i], 1'b1, p);
         rd_ck(ofs[i], p);
         ck("gate rst", p, prst[i*32+:32]);
         ck("gate clk", ~p, pclk[i*32+:32]);
         ck("gate sfr", ~p, pok[i*32+:32]);
         xfer(ofs[i], 1'b1, 32'h0);
         step(1);
         ck("ungate clk", 32'hffff_ffff, pclk[i*32+:32]);
      end
   endtask : t_gates
   // Low-power control fields, reserved bits read zero
   task automatic t_ctrl;
      xfer(PMG_RTC_CTRL_OFS, 1'b1, 32'hffff_ffff);
      rd_ck(PMG_RTC_CTRL_OFS, 32'h300);
      ck("rtc sel", 32'h3, {30'h0, rtc});
      xfer(PMG_PWR_CTRL_OFS, 1'b1, 32'h1);
      rd_ck(PMG_PWR_CTRL_OFS, 32'h1);
      ck("standby run", 32'h0, {31'h0, vreg});
   endtask : t_ctrl
   // Idle entry, stop-in-idle and priority wake
   task automatic t_idle;
      xfer(PMG_OSC_CTRL_OFS, 1'b1, 32'h0);
      @(posedge clk);
      stop <= 224'h1;
      go_wait();
      ck("idle mode", 32'h6, {29'h0, pben, fsen, cpu_en});
      ck("idle stop", 32'h2, {30'h0, pclk[1:0]});
      rd_ck(PMG_STATUS_OFS, 32'h1);
      set_irq(1'b1, 3'h3, 1'b0);
      ck("idle equal", 32'h0, {31'h0, cpu_en});
      set_irq(1'b1, 3'h4, 1'b0);
      ck("idle wake", 32'h1, {31'h0, cpu_en});
      set_irq(1'b0, 3'h0, 1'b0);
      stop <= 224'h0;
   endtask : t_idle
   // Watchdog timeout in idle wakes with an interrupt pulse
   task automatic t_idle_wdt;
      logic seen;
      go_wait();
      pulse_wdt(seen);
      ck("wdt wake irq", 32'h1, {31'h0, seen});
      ck("wdt idle run", 32'h1, {31'h0, cpu_en});
   endtask : t_idle_wdt
   // Sleep entry, ignored source, low priority wake to idle
   task automatic t_sleep;
      xfer(PMG_OSC_CTRL_OFS, 1'b1, 32'h10);
      go_wait();
      ck("sleep mode", 32'h18, {27'h0, hold, boren, wclr, pben, fsen});
      ck("sleep gates", 32'h5, {29'h0, pclk[1:0], vreg});
      set_irq(1'b1, 3'h7, 1'b0);
      ck("sleep other src", 32'h1, {31'h0, hold});
      set_irq(1'b1, 3'h2, 1'b1);
      ck("sleep to idle", 32'h2, {29'h0, hold, pben, cpu_en});
      set_irq(1'b1, 3'h5, 1'b1);
      ck("idle after sleep", 32'h1, {31'h0, cpu_en});
      set_irq(1'b0, 3'h0, 1'b0);
   endtask : t_sleep
   // Wake delay from sleep for one oscillator choice
   task automatic t_wake(input logic [31:0] osc, input int n);
      int c;
      xfer(PMG_OSC_CTRL_OFS, 1'b1, osc);
      go_wait();
      @(posedge clk);
      irq_on <= 1'b1;
      irq_p <= 3'h6;
      irq_s <= 1'b1;
      c = 0;
      do
      begin
         step(1);
         c++;
      end while (cpu_en !== 1'b1 && c < 400);
      ck("wake delay", 32'h1, {31'h0, c >= n && c <= n + 6});
      set_irq(1'b0, 3'h0, 1'b0);
   endtask : t_wake
   // Watchdog and reset end sleep
   task automatic t_sleep_exit;
      logic seen;
      xfer(PMG_OSC_CTRL_OFS, 1'b1, 32'h10);
      go_wait();
      pulse_wdt(seen);
      step(20);
      ck("wdt sleep", 32'h1, {seen, cpu_en});
      xfer(ofs[6], 1'b1, 32'h10);
      go_wait();
      @(posedge clk);
      rst_n <= 1'b0;
      step(2);
      ck("reset wake", 32'h1, {hold, cpu_en});
      rst_n <= 1'b1;
      rd_ck(ofs[6], 32'h0);
   endtask : t_sleep_exit
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {rst_n, hsel, hwrite, req_wait, req_wdt, irq_on, irq_s} = '0;
      {haddr, htrans, hwdata, irq_p, stop} = '0;
      hsize = 3'h2;
      cpu_prio = 3'h3;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_gates();
      t_ctrl();
      t_idle();
      t_idle_wdt();
      t_sleep();
      t_wake(32'h10, int'(PMG_WAKE_FAST_CYC));
      t_wake(32'h11, int'(PMG_WAKE_SLOW_CYC));
      t_sleep_exit();
      stop_test();
   end
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      stop_test();
   end
endmodule : tb
bind pmg_power_ctrl pmg_power_ctrl_props #(.NUM_GATES(NUM_GATES), .PRIO_W(PRIO_W)) props (.*);

// File: shared/pmg_gate_if.sv
// Interface between the controller and its bank of module gate registers
`timescale 1ns/1ns
interface pmg_gate_if;
   logic wr_en; // Write strobe for one gate register
   logic [2:0] wr_idx; // Register written
   logic [31:0] wr_data; // Data written
   logic [2:0] rd_idx; // Register read
   logic [31:0] rd_data; // Data read back
   logic [7*32-1:0] gates; // All gate bits, register 0 in the low word

   modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx,
      input rd_data, input gates);
   modport bank (input wr_en, input wr_idx, input wr_data, input rd_idx,
      output rd_data, output gates);
endinterface : pmg_gate_if

// File: shared/pmg_pkg.sv
// Package with register map, field layout, timing and state types of the power-mode controller
package pmg_pkg;
   // Register byte offsets
   localparam logic [7:0] PMG_OSC_CTRL_OFS = 8'h00;
   localparam logic [7:0] PMG_RTC_CTRL_OFS = 8'h04;
   localparam logic [7:0] PMG_PWR_CTRL_OFS = 8'h08;
   localparam logic [7:0] PMG_STATUS_OFS = 8'h0c;
   localparam logic [7:0] PMG_GATE_ANALOG_OFS = 8'h40;
   localparam logic [7:0] PMG_GATE_CMP_OPAMP_OFS = 8'h50;
   localparam logic [7:0] PMG_GATE_CAPCMP_OFS = 8'h60;
   localparam logic [7:0] PMG_GATE_TMR_PWM_OFS = 8'h70;
   localparam logic [7:0] PMG_GATE_SERIAL_OFS = 8'h80;
   localparam logic [7:0] PMG_GATE_REFCLK_ENC_OFS = 8'h90;
   localparam logic [7:0] PMG_GATE_DMA_OFS = 8'ha0;
   // Module gate registers sit on a 16-byte stride
   localparam int PMG_GATE_STRIDE_LSB = 4;
   localparam int PMG_NUM_GATE_REGS = 7;
   // Field positions
   localparam int PMG_SLEEP_EN_BIT = 4;
   localparam int PMG_OSC_SLOW_BIT = 0;
   localparam int PMG_RTC_SEL_LSB = 8;
   localparam int PMG_VREG_STBY_BIT = 0;
   // Reset values
   localparam logic [31:0] PMG_GATE_RST = 32'h0000_0000;
   localparam logic [1:0] PMG_RTC_SEL_RST = 2'h0;
   // Wake-up delay per oscillator, in ns, and derived cycle counts at 8 ns
   localparam int PMG_CLK_NS = 8;
   localparam int PMG_WAKE_FAST_NS = 80;
   localparam int PMG_WAKE_SLOW_NS = 2000;
   localparam logic [15:0] PMG_WAKE_FAST_CYC =
      16'((PMG_WAKE_FAST_NS + PMG_CLK_NS - 1) / PMG_CLK_NS);
   localparam logic [15:0] PMG_WAKE_SLOW_CYC =
      16'((PMG_WAKE_SLOW_NS + PMG_CLK_NS - 1) / PMG_CLK_NS);

   // Operating modes
   typedef enum logic [1:0] {PMG_RUN, PMG_IDLE, PMG_SLEEP, PMG_WAKE} pmg_mode_e;

   // Complete state of the controller
   typedef struct packed {
      pmg_mode_e mode;
      logic [15:0] wake_cnt;
      logic dph_wr;
      logic rd_wait;
      logic [7:0] dph_addr;
      logic [31:0] hrdata;
      logic sleep_en;
      logic osc_slow;
      logic [1:0] rtc_sel;
      logic vreg_stby;
      logic wdt_irq;
   } pmg_ctl_s;
endpackage : pmg_pkg

// File: verilog/pmg_gate_bank.sv
// Bank of module gate registers, one word each
`timescale 1ns/1ns
module pmg_gate_bank
   import pmg_pkg::*;
#(
   parameter int NUM_REGS = PMG_NUM_GATE_REGS
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Controller side
   pmg_gate_if.bank gif
);

   // Bank state as one packed struct
   typedef struct packed {
      logic [NUM_REGS-1:0][31:0] word;
   } pmg_bank_s;

   pmg_bank_s bank_reg; // Registered bank
   pmg_bank_s bank_next; // Next bank value

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Write one word per strobe
   always_comb
   begin
      bank_next = bank_reg;
      if (gif.wr_en && (32'(gif.wr_idx) < NUM_REGS))
      begin
         bank_next.word[gif.wr_idx] = gif.wr_data;
      end
   end

   // All words clear on any reset
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bank_reg <= '{word: '{default: PMG_GATE_RST}};
      end
      else
      begin
         bank_reg <= bank_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read port, unused indices read as zero
   assign gif.rd_data = (32'(gif.rd_idx) < NUM_REGS) ? bank_reg.word[gif.rd_idx] : 32'h0;

   // Flatten the words onto the gate bus
   genvar g;
   generate
      for (g = 0; g < 7; g++)
      begin : g_word
         if (g < NUM_REGS)
         begin : g_used
            assign gif.gates[g*32 +: 32] = bank_reg.word[g];
         end
         else
         begin : g_unused
            assign gif.gates[g*32 +: 32] = 32'h0;
         end
      end
   endgenerate

endmodule : pmg_gate_bank

// File: verilog/pmg_power_ctrl.sv
// Power-mode controller with Sleep/Idle sequencing and per-peripheral module gating
//
// Functional notes
// - Sleep halts CPU, gates most peripheral clocks
// - Sleep wake delay depends on oscillator
// - Clock-fail monitor off throughout Sleep
// - Brown-out detector stays on in Sleep
// - Sleep entry never clears the watchdog
// - Sleep-capable peripherals keep running in Sleep
// - I/O pins hold their drive in Sleep
// - Higher-priority sleep-source interrupt ends Sleep
// - Lower/equal wake interrupt moves Sleep to Idle
// - Reset or watchdog timeout ends Sleep/Idle
// - Idle halts CPU and stop-in-idle peripherals, other clocks run
// - Stop-in-idle bit halts peripheral in Idle
// - Wait with sleep enable clear enters Idle
// - Idle wakes on higher-priority interrupt or watchdog timeout
// - Watchdog timeout in Idle raises wake interrupt
// - RTC source, sleep enable, regulator standby controls
// - Module-disable bit stops its own peripheral's clock
// - Disabled peripheral registers ignore access
// - Gate bit one disables, zero enables
// - Gate registers reset to zero
// - Gating resets peripheral registers
`timescale 1ns/1ns
module pmg_power_ctrl
   import pmg_pkg::*;
#(
   parameter int NUM_GATES = 32 * PMG_NUM_GATE_REGS, // Gate bits in the bank
   parameter logic [NUM_GATES-1:0] SLEEP_CAPABLE = '0, // Peripherals that run in Sleep
   parameter int PRIO_W = 3 // Interrupt priority width
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // CPU core
   input wire logic i_wait_exec,
   input wire logic [PRIO_W-1:0] i_cpu_prio,
   output logic o_cpu_clk_en,
   // Interrupt controller
   input wire logic i_irq_req,
   input wire logic [PRIO_W-1:0] i_irq_prio,
   input wire logic i_irq_sleep_src,
   // Watchdog
   input wire logic i_wdt_timeout,
   output logic o_wdt_clear,
   output logic o_wdt_wake_irq,
   // System clocks and supervisors
   output logic o_pbclk_en,
   output logic o_clk_mon_en,
   output logic o_brownout_en,
   output logic o_io_hold,
   output logic [1:0] o_rtc_clk_sel,
   output logic o_vreg_standby,
   // Peripherals
   input wire logic [NUM_GATES-1:0] i_periph_stop_idle,
   output logic [NUM_GATES-1:0] o_periph_clk_en,
   output logic [NUM_GATES-1:0] o_periph_rst,
   output logic [NUM_GATES-1:0] o_periph_sfr_ok
);

   pmg_ctl_s ctl_reg; // Registered state
   pmg_ctl_s ctl_next; // Next state
   pmg_gate_if gif(); // Link to the gate bank
   logic [NUM_GATES-1:0] gate_bits; // Module disable bits
   logic addr_ok; // Address phase accepted this cycle
   logic wr_gate; // Data-phase write hits the gate bank
   logic [2:0] wr_gate_idx; // Gate register written
   logic rd_gate; // Read address hits the gate bank
   logic [2:0] rd_gate_idx; // Gate register read
   logic irq_above; // Interrupt outranks the CPU
   logic in_sleep; // Sleep mode
   logic in_idle; // Idle mode

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Gate register decode: 0x40..0xa0 on a 16-byte stride
   function automatic logic gate_hit(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - PMG_GATE_ANALOG_OFS;
      gate_hit = (addr >= PMG_GATE_ANALOG_OFS) && (addr <= PMG_GATE_DMA_OFS)
         && (rel[PMG_GATE_STRIDE_LSB-1:0] == 4'h0);
   endfunction : gate_hit

   // Word index of a gate register
   function automatic logic [2:0] gate_idx(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - PMG_GATE_ANALOG_OFS;
      gate_idx = rel[PMG_GATE_STRIDE_LSB +: 3];
   endfunction : gate_idx

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Gate bank
   pmg_gate_bank #(
      .NUM_REGS(PMG_NUM_GATE_REGS)
   ) u_gate_bank (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .gif(gif.bank)
   );

   // Bank connections
   assign wr_gate = ctl_reg.dph_wr && gate_hit(ctl_reg.dph_addr);
   assign wr_gate_idx = gate_idx(ctl_reg.dph_addr);
   assign rd_gate = gate_hit(ctl_reg.dph_addr);
   assign rd_gate_idx = gate_idx(ctl_reg.dph_addr);
   assign gif.wr_en = wr_gate;
   assign gif.wr_idx = wr_gate_idx;
   assign gif.wr_data = i_hwdata;
   assign gif.rd_idx = rd_gate_idx;
   assign gate_bits = gif.gates[NUM_GATES-1:0];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helper terms
   assign addr_ok = i_hsel && i_hready && i_htrans[1];
   assign irq_above = i_irq_req && (i_irq_prio > i_cpu_prio);
   assign in_sleep = (ctl_reg.mode == PMG_SLEEP);
   assign in_idle = (ctl_reg.mode == PMG_IDLE);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus slave, control registers and mode sequencer
   always_comb
   begin
      ctl_next = ctl_reg;
      ctl_next.wdt_irq = 1'b0;

      // Address phase: reads insert one wait state to fetch data
      ctl_next.dph_wr = 1'b0;
      if (addr_ok)
      begin
         ctl_next.dph_addr = i_haddr;
         ctl_next.dph_wr = i_hwrite;
         ctl_next.rd_wait = !i_hwrite;
      end
      else if (ctl_reg.rd_wait)
      begin
         // Wait state: capture read data, unmapped reads give zero
         ctl_next.rd_wait = 1'b0;
         ctl_next.hrdata = 32'h0;
         if (rd_gate)
         begin
            ctl_next.hrdata = gif.rd_data;
         end
         else
         begin
            unique case (ctl_reg.dph_addr)
               PMG_OSC_CTRL_OFS:
               begin
                  ctl_next.hrdata[PMG_SLEEP_EN_BIT] = ctl_reg.sleep_en;
                  ctl_next.hrdata[PMG_OSC_SLOW_BIT] = ctl_reg.osc_slow;
               end
               PMG_RTC_CTRL_OFS:
               begin
                  ctl_next.hrdata[PMG_RTC_SEL_LSB +: 2] = ctl_reg.rtc_sel;
               end
               PMG_PWR_CTRL_OFS:
               begin
                  ctl_next.hrdata[PMG_VREG_STBY_BIT] = ctl_reg.vreg_stby;
               end
               PMG_STATUS_OFS:
               begin
                  // Live mode flags
                  ctl_next.hrdata[0] = in_idle;
                  ctl_next.hrdata[1] = in_sleep;
                  ctl_next.hrdata[2] = (ctl_reg.mode == PMG_WAKE);
               end
               default:
               begin
                  ctl_next.hrdata = 32'h0;
               end
            endcase
         end
      end

      // Data phase write to the low-power controls
      if (ctl_reg.dph_wr)
      begin
         unique case (ctl_reg.dph_addr)
            PMG_OSC_CTRL_OFS:
            begin
               ctl_next.sleep_en = i_hwdata[PMG_SLEEP_EN_BIT];
               ctl_next.osc_slow = i_hwdata[PMG_OSC_SLOW_BIT];
            end
            PMG_RTC_CTRL_OFS:
            begin
               ctl_next.rtc_sel = i_hwdata[PMG_RTC_SEL_LSB +: 2];
            end
            PMG_PWR_CTRL_OFS:
            begin
               ctl_next.vreg_stby = i_hwdata[PMG_VREG_STBY_BIT];
            end
            default:
            begin
               // Status, gate bank and unmapped words need nothing here
            end
         endcase
      end

      // Mode sequencer
      unique case (ctl_reg.mode)
         PMG_RUN:
         begin
            if (i_wait_exec)
            begin
               // Sleep enable picks the depth of the low-power state
               if (ctl_reg.sleep_en)
               begin
                  ctl_next.mode = PMG_SLEEP;
               end
               else
               begin
                  ctl_next.mode = PMG_IDLE;
               end
            end
         end
         PMG_SLEEP:
         begin
            if (i_wdt_timeout || (irq_above && i_irq_sleep_src))
            begin
               // Leave Sleep through the oscillator start-up delay
               ctl_next.mode = PMG_WAKE;
               ctl_next.wake_cnt = ctl_reg.osc_slow ? PMG_WAKE_SLOW_CYC
                  : PMG_WAKE_FAST_CYC;
            end
            else if (i_irq_req && i_irq_sleep_src)
            begin
               // Not urgent enough for the CPU: clocks resume in Idle, CPU stays halted
               ctl_next.mode = PMG_IDLE;
            end
         end
         PMG_WAKE:
         begin
            // Count down the wake-up delay
            if (ctl_reg.wake_cnt <= 16'h1)
            begin
               ctl_next.mode = PMG_RUN;
               ctl_next.wake_cnt = 16'h0;
            end
            else
            begin
               ctl_next.wake_cnt = ctl_reg.wake_cnt - 16'h1;
            end
         end
         PMG_IDLE:
         begin
            if (i_wdt_timeout)
            begin
               // Timeout becomes a wake interrupt to the CPU
               ctl_next.wdt_irq = 1'b1;
               ctl_next.mode = PMG_RUN;
            end
            else if (irq_above)
            begin
               ctl_next.mode = PMG_RUN;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State register; any reset returns to Run
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctl_reg <= '0;
         ctl_reg.mode <= PMG_RUN;
         ctl_reg.rtc_sel <= PMG_RTC_SEL_RST;
      end
      else
      begin
         ctl_reg <= ctl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus answers
   assign o_hrdata = ctl_reg.hrdata;
   assign o_hreadyout = !ctl_reg.rd_wait;
   assign o_hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // System-level clock and supervisor controls
   assign o_cpu_clk_en = (ctl_reg.mode == PMG_RUN);
   assign o_pbclk_en = !in_sleep && (ctl_reg.mode != PMG_WAKE);
   assign o_clk_mon_en = !in_sleep && (ctl_reg.mode != PMG_WAKE);
   assign o_brownout_en = 1'b1;
   assign o_wdt_clear = 1'b0;
   assign o_wdt_wake_irq = ctl_reg.wdt_irq;
   assign o_io_hold = in_sleep;
   assign o_rtc_clk_sel = ctl_reg.rtc_sel;
   assign o_vreg_standby = ctl_reg.vreg_stby && in_sleep;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Per-peripheral clock, reset and register-access controls
   genvar p;
   generate
      for (p = 0; p < NUM_GATES; p++)
      begin : g_periph
         // A set gate bit overrides every mode
         assign o_periph_clk_en[p] = !gate_bits[p]
            && !(in_sleep && !SLEEP_CAPABLE[p])
            && !(in_idle && i_periph_stop_idle[p]);
         assign o_periph_rst[p] = gate_bits[p];
         assign o_periph_sfr_ok[p] = !gate_bits[p];
      end
   endgenerate

endmodule : pmg_power_ctrl
